// [src/tws_pkg.sv]
package tws_pkg;

  // ----------------------------------------------------------------
  // frame layout and counts
  // ----------------------------------------------------------------
  localparam int          START_BITS   = 3;
  localparam int          SETUP_BITS   = 4;
  localparam int          STOP_BITS    = 3;
  localparam int          FRAME_BITS   = START_BITS + SETUP_BITS + STOP_BITS;
  localparam int          WORD_BITS    = 16;
  localparam int          ACK_CLOCKS   = 2;
  localparam int          RESULT_CLKS  = 17;
  localparam int          RST_PAT_BITS = 21;
  localparam logic [4:0]  CNT_RESET    = 5'h00;
  localparam logic        DOUT_RESET   = 1'b0;

  // ----------------------------------------------------------------
  // setup codes and reset pattern, plain defaults
  // ----------------------------------------------------------------
  localparam logic [3:0]  CODE_PRESS   = 4'hA;
  localparam logic [3:0]  CODE_TEMP    = 4'h9;
  localparam logic [3:0]  CODE_CAL1    = 4'h5;
  localparam logic [3:0]  CODE_CAL2    = 4'h6;
  localparam logic [3:0]  CODE_CAL3    = 4'h3;
  localparam logic [3:0]  CODE_CAL4    = 4'hC;
  localparam logic [20:0] RESET_PAT    = 21'h155540;

  // host-driven two of the three wires, sclk and din
  typedef struct packed {
    logic sclk;
    logic din;
  } tws_link_s;

  // conversion request to the analog side
  typedef struct packed {
    logic        start;
    logic        isTemp;
  } tws_conv_s;

  typedef enum logic [2:0] {
    ST_FRAME, ST_ACK, ST_WAIT, ST_RESULT, ST_CAL
  } tws_state_e;

endpackage

// [src/tws_cal_rom.sv]
`timescale 1ns/1ps
module tws_cal_rom #(
  parameter logic [63:0] CAL_INIT = 64'h0123_4567_89AB_CDEF
) (
  input  wire logic       clock,
  input  wire logic [1:0] sel,
  output logic [15:0]     word
);
  // ------------------------------------------------------------
  // calibration store, registered read
  // ------------------------------------------------------------
  logic [15:0] mem [4];

  // words are packed first-word-highest
  for (genvar i = 0; i < 4; i++) begin : g_word
    assign mem[i] = CAL_INIT[63-16*i -: 16];
  end

  // registered output keeps the read path timing-clean
  always_ff @(posedge clock) begin
    word <= mem[sel];
  end
endmodule

// [src/tws_readout.sv]
`timescale 1ns/1ps
module tws_readout #(
  parameter logic [63:0] CAL_INIT = 64'h0123_4567_89AB_CDEF
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire tws_pkg::tws_link_s link,
  output logic                    dout,
  output tws_pkg::tws_conv_s      conv,
  input  wire logic               convDone,
  input  wire logic [15:0]        convData
);
  import tws_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers and edge detect
  // ------------------------------------------------------------
  logic [1:0] sclkSync_r;
  logic [1:0] dinSync_r;
  logic       sclkLast_r;
  logic       rise;

  // pins come from the host's domain: two flops before any use
  always_ff @(posedge clock) begin
    if (rst) begin
      sclkSync_r <= 2'h0;
      dinSync_r  <= 2'h0;
      sclkLast_r <= 1'b0;
    end else begin
      sclkSync_r <= {sclkSync_r[0], link.sclk};
      dinSync_r  <= {dinSync_r[0], link.din};
      sclkLast_r <= sclkSync_r[1];
    end
  end

  assign rise = sclkSync_r[1] & ~sclkLast_r;

  // ------------------------------------------------------------
  // reset pattern watcher
  // ------------------------------------------------------------
  logic [20:0] histR_r;
  logic        patHit;

  // runs in every state, so the pattern always wins
  always_ff @(posedge clock) begin
    if (rst) begin
      histR_r <= 21'h000000;
    end else if (rise) begin
      histR_r <= {histR_r[19:0], dinSync_r[1]};
    end
  end

  assign patHit = rise && ({histR_r[19:0], dinSync_r[1]} == RESET_PAT);

  // ------------------------------------------------------------
  // calibration store
  // ------------------------------------------------------------
  logic [1:0]  calSel_r;
  logic [15:0] calWord;

  tws_cal_rom #(.CAL_INIT(CAL_INIT)) u_rom (
    .clock (clock),
    .sel   (calSel_r),
    .word  (calWord)
  );

  // ------------------------------------------------------------
  // frame decode
  // ------------------------------------------------------------
  function automatic logic [2:0] decodeSetup(input logic [3:0] code);
    // {valid, kind[1:0]}: kind 0 press, 1 temp, 2 calib
    case (code)
      CODE_PRESS: decodeSetup = 3'h4;
      CODE_TEMP:  decodeSetup = 3'h5;
      CODE_CAL1, CODE_CAL2, CODE_CAL3, CODE_CAL4: decodeSetup = 3'h6;
      default:    decodeSetup = 3'h0;
    endcase
  endfunction

  function automatic logic [1:0] calIndex(input logic [3:0] code);
    case (code)
      CODE_CAL2: calIndex = 2'h1;
      CODE_CAL3: calIndex = 2'h2;
      CODE_CAL4: calIndex = 2'h3;
      default:   calIndex = 2'h0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // protocol state machine
  // ------------------------------------------------------------
  tws_state_e  state_r;
  logic [4:0]  cnt_r;
  logic [15:0] shift_r;
  logic [9:0]  frame;
  logic [2:0]  dec;
  logic        ackEdge;
  logic        pend_r;
  logic        calLoad_r;
  logic        doneSync_r;
  logic        doneMeta_r;

  assign frame = {histR_r[8:0], dinSync_r[1]};
  assign dec   = decodeSetup(frame[6:3]);
  // start/stop framing around the setup code
  assign ackEdge = rise && state_r == ST_FRAME && cnt_r == 5'(FRAME_BITS - 1)
                   && frame[9:7] == 3'h7 && frame[2:0] == 3'h0 && dec[2];

  // done flag comes from the converter, treated as foreign
  always_ff @(posedge clock) begin
    if (rst) begin
      doneMeta_r <= 1'b0;
      doneSync_r <= 1'b0;
    end else begin
      doneMeta_r <= convDone;
      doneSync_r <= doneMeta_r;
    end
  end

  // one step per serial clock rise, except ST_WAIT which leaves on done; reset pattern overrides all
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r  <= ST_FRAME;
      cnt_r    <= CNT_RESET;
      calSel_r <= 2'h0;
      pend_r   <= 1'b0;
    end else if (patHit) begin
      state_r <= ST_FRAME;
      cnt_r   <= CNT_RESET;
      pend_r  <= 1'b0;
    end else begin
      case (state_r)
        ST_FRAME: if (rise) begin
          if (ackEdge) begin
            cnt_r <= CNT_RESET;
            if (dec[1]) begin
              calSel_r <= calIndex(frame[6:3]);
              state_r  <= ST_CAL;
              pend_r   <= 1'b1;
            end else begin
              state_r <= ST_ACK;
            end
          end else if (cnt_r == 5'(FRAME_BITS - 1)) begin
            cnt_r <= CNT_RESET;
          end else if (cnt_r != CNT_RESET || dinSync_r[1]) begin
            cnt_r <= cnt_r + 5'h01; // hunt for start bits
          end
        end
        ST_ACK: if (rise) begin
          if (cnt_r == 5'(ACK_CLOCKS - 1)) begin
            cnt_r   <= CNT_RESET;
            state_r <= ST_WAIT;
          end else begin
            cnt_r <= cnt_r + 5'h01;
          end
        end
        ST_WAIT: if (doneSync_r) begin
          state_r <= ST_RESULT;
        end
        ST_RESULT, ST_CAL: begin
          pend_r <= 1'b0;
          if (rise) begin
            if (cnt_r == 5'(RESULT_CLKS - 1)) begin
              cnt_r   <= CNT_RESET;
              state_r <= ST_FRAME;
            end else begin
              cnt_r <= cnt_r + 5'h01; // held clock simply waits
            end
          end
        end
        default: state_r <= ST_FRAME;
      endcase
    end
  end

  // select is registered and so is the rom, so the load waits one more cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      calLoad_r <= 1'b0;
    end else begin
      calLoad_r <= state_r == ST_CAL && pend_r && !patHit;
    end
  end

  // conversion request to the analog side, one cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      conv <= '0;
    end else begin
      conv.start  <= ackEdge && !dec[1] && !patHit;
      conv.isTemp <= dec[0];
    end
  end

  // ------------------------------------------------------------
  // output line and shifter
  // ------------------------------------------------------------
  // data changes on serial clock rises, except the drop to 0 when the conversion is done
  always_ff @(posedge clock) begin
    if (rst) begin
      shift_r <= 16'h0000;
      dout    <= DOUT_RESET;
    end else if (patHit) begin
      dout <= DOUT_RESET;
    end else if (ackEdge && !dec[1]) begin
      dout <= 1'b1;
    end else if (state_r == ST_WAIT && doneSync_r) begin
      dout    <= 1'b0;
      shift_r <= convData;
    end else if (calLoad_r) begin
      shift_r <= calWord; // word of the new select, two cycles on
    end else if (rise && (state_r == ST_RESULT || state_r == ST_CAL)) begin
      dout    <= shift_r[15];
      shift_r <= {shift_r[14:0], 1'b0};
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_ackRise;
    ackEdge && !dec[1] && !patHit;
  endsequence

  a_ack_high: assert property (@(posedge clock) disable iff (rst)
    s_ackRise |=> dout && state_r == ST_ACK)
    else $error("acknowledge not raised");

  a_done_low: assert property (@(posedge clock) disable iff (rst)
    (state_r == ST_WAIT && doneSync_r && !patHit) |=> !dout && state_r == ST_RESULT)
    else $error("completion not signalled");

  a_pat_idle: assert property (@(posedge clock) disable iff (rst)
    patHit |=> state_r == ST_FRAME && cnt_r == CNT_RESET)
    else $error("reset pattern ignored");

  a_hold_dout: assert property (@(posedge clock) disable iff (rst)
    (!rise && (state_r == ST_RESULT) && !$past(rst)) |=> $stable(dout))
    else $error("output moved without clock");

  a_conv_pulse: assert property (@(posedge clock) disable iff (rst)
    conv.start |=> !conv.start)
    else $error("conversion start too long");

  a_cal_load: assert property (@(posedge clock) disable iff (rst)
    (ackEdge && dec[1] && !patHit) |=> state_r == ST_CAL ##2 shift_r == calWord)
    else $error("calibration word not loaded");

endmodule

// [sim/tws_host_model.sv]
`timescale 1ns/1ps
module tws_host_model (
  output tws_pkg::tws_link_s link,
  input  wire logic          dout
);
  import tws_pkg::*;

  logic lastOut;  // dout as captured at the latest falling edge

  // clock stands low between frames; the host alone makes it
  initial begin
    link = '0;
  end

  // one bit: data changes at the fall, device reads it at the rise
  task automatic clk(input logic d);
    link.din = d;
    #40;
    link.sclk = 1'b1;
    #40;
    lastOut = dout;
    link.sclk = 1'b0;
  endtask

  // msb first, n bits taken from the low end of bits
  task automatic send(input logic [20:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      clk(bits[i]);
    end
  endtask

  // start, setup code, stop
  task automatic frame(input logic [3:0] code);
    send({11'h000, 3'h7, code, 3'h0}, FRAME_BITS);
  endtask

  // seventeen clocks, a pause of clock low may be placed after any bit
  task automatic readWord(output logic [15:0] w, input int pauseAt);
    for (int i = 0; i < RESULT_CLKS; i++) begin
      clk(1'b0);
      if (i < WORD_BITS) w[WORD_BITS-1-i] = lastOut;
      if (i == pauseAt) #400;
    end
  endtask
endmodule

// [sim/tws_readout_tb.sv]
`timescale 1ns/1ps
module tws_readout_tb;
  import tws_pkg::*;

  localparam logic [63:0] CAL = 64'hA5C3_1E87_F00D_5A69;

  logic        clock    = 1'b0;
  logic        rst;
  logic        convDone;
  logic [15:0] convData;
  logic        dout;
  tws_link_s   link;
  tws_conv_s   conv;
  logic        lastTemp;
  int          starts   = 0;
  int          fails    = 0;
  int          checks   = 0;

  always #2 clock = ~clock;

  // count conversion requests and keep their kind; read mid-cycle, off the launch edge
  always @(negedge clock) begin
    if (conv.start === 1'b1) begin
      starts++;
      lastTemp = conv.isTemp;
    end
  end

  tws_readout #(.CAL_INIT(CAL)) u_dut (
    .clock(clock), .rst(rst), .link(link), .dout(dout),
    .conv(conv), .convDone(convDone), .convData(convData)
  );
  tws_host_model u_host (.link(link), .dout(dout));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // bounded wait for a level on dout
  task automatic waitDout(input logic lvl);
    for (int n = 0; n < 100 && dout !== lvl; n++) @(negedge clock);
    check(16'(dout), 16'(lvl));
    if (dout !== lvl) stop_test();
  endtask

  // conversion with acknowledge, hold, done edge and paused readout
  task automatic conversion(input logic isTemp, input logic [15:0] data, input int pauseAt);
    int          n0;
    logic [15:0] w;
    n0 = starts;
    u_host.send(RESET_PAT, RST_PAT_BITS);
    u_host.frame(isTemp ? CODE_TEMP : CODE_PRESS);
    check(16'(u_host.lastOut), 16'h0001);
    u_host.clk(1'b0);
    u_host.clk(1'b0);
    check(16'(u_host.lastOut), 16'h0001);
    check(16'(starts - n0), 16'h0001);
    check(16'(lastTemp), 16'(isTemp));
    repeat (40) @(negedge clock);
    check(16'(dout), 16'h0001);
    convData = data;
    convDone = 1'b1;
    waitDout(1'b0);
    u_host.readWord(w, pauseAt);
    check(w, data);
    check(16'(u_host.lastOut), 16'h0000);
    @(negedge clock);
    convDone = 1'b0;
  endtask

  // calibration word follows the stop field directly
  task automatic calRead(input logic [3:0] code, input logic [15:0] word);
    logic [15:0] w;
    u_host.frame(code);
    u_host.readWord(w, 99);
    check(w, word);
  endtask

  // unknown setup code gets no answer and no conversion
  task automatic refused();
    int n0;
    n0 = starts;
    u_host.frame(4'h0);
    u_host.clk(1'b0);
    check(16'(u_host.lastOut), 16'h0000);
    check(16'(starts - n0), 16'h0000);
  endtask

  // reset pattern while waiting on a conversion returns to idle
  task automatic resetMid();
    u_host.frame(CODE_PRESS);
    u_host.clk(1'b0);
    u_host.clk(1'b0);
    u_host.send(RESET_PAT, RST_PAT_BITS);
    repeat (8) @(negedge clock);
    check(16'(dout), 16'h0000);
    calRead(CODE_CAL1, CAL[63:48]);
  endtask

  initial begin
    rst      = 1'b1;
    convDone = 1'b0;
    convData = 16'h0000;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    check({14'h0000, dout, conv.start}, 16'h0000);
    conversion(1'b0, 16'hB2E4, 5);
    conversion(1'b1, 16'h4D1B, 15);
    calRead(CODE_CAL1, CAL[63:48]);
    calRead(CODE_CAL2, CAL[47:32]);
    calRead(CODE_CAL3, CAL[31:16]);
    calRead(CODE_CAL4, CAL[15:0]);
    refused();
    resetMid();
    conversion(1'b0, 16'h8001, 0);
    stop_test();
  end
endmodule
